// ### inc/xsfr_cfg.svh
// Address map, reset values and field positions of the extended register bank
`ifndef XSFR_CFG_SVH
`define XSFR_CFG_SVH
`define EXT_AREA_LO 20'hf0000
`define EXT_AREA_HI 20'hf07ff
`define PRI_AREA_LO 20'hfff00
`define PRI_AREA_HI 20'hfffff
`define ADDR_RESET_CAUSE 20'hfffa8
`define ADDR_WDOG_ENABLE 20'hfffab
`define WDOG_EN_RST_OFF 8'h1a
`define WDOG_EN_RST_ON 8'h9a
`define RCR_BIT_TRAP 3
`define RCR_BIT_WDOG 2
`define RCR_BIT_BADMEM 1
`define RCR_BIT_SUPPLY 0
`define OFS_ADC_MODE_TWO 20'hf0010
`define OFS_ADC_TEST_SELECT 20'hf0013
`define OFS_PULLUP_PORT0 20'hf0030
`define OFS_PULLUP_PORT2 20'hf0032
`define OFS_PULLUP_PORT4 20'hf0034
`define OFS_PULLUP_PORT12 20'hf003c
`define OFS_INPUT_LEVEL_PORT14 20'hf004e
`define OFS_OUTPUT_TYPE_PORT0 20'hf0050
`define OFS_OUTPUT_TYPE_PORT2 20'hf0052
`define OFS_OUTPUT_TYPE_PORT4 20'hf0054
`define OFS_ANADIG_PORT0 20'hf0060
`define OFS_ANADIG_PORT2 20'hf0062
`define OFS_GLITCH_EN0 20'hf0070
`define OFS_GLITCH_EN1 20'hf0071
`define OFS_INPUT_SWITCH 20'hf0073
`define OFS_PIN_REDIRECT2 20'hf0075
`define OFS_PIN_REDIRECT0 20'hf0077
`define OFS_PIN_REDIRECT1 20'hf0079
`define OFS_PIN_REDIRECT3 20'hf007c
`define OFS_FAST_OSC_TRIM 20'hf00a0
`define OFS_FAST_OSC_DIV 20'hf00a8
`define OFS_FLASH_FREQ 20'hf00be
`define OFS_FLASH_MODE 20'hf00c0
`define OFS_FLASH_SEQ_CTRL 20'hf00c1
`define OFS_FLASH_PTR_LO 20'hf00c2
`define OFS_FLASH_PTR_HI 20'hf00c3
`define OFS_FLASH_END_LO 20'hf00c4
`define OFS_FLASH_END_HI 20'hf00c5
`define OFS_FLASH_STAT_LO 20'hf00c6
`define OFS_FLASH_STAT_HI 20'hf00c7
`define OFS_FLASH_WBUF0 20'hf00c8
`define OFS_FLASH_WBUF1 20'hf00c9
`define OFS_FLASH_WBUF2 20'hf00ca
`define OFS_FLASH_WBUF3 20'hf00cb
`define OFS_PERIPH_CLK_EN0 20'hf00f0
`define OFS_SPEED_MODE 20'hf00f3
`define OFS_DECIMAL_ADJUST 20'hf00fe
`define RST_ZERO 8'h00
`define RST_PULLUP_PORT4 8'h01
`define RST_ANADIG_PORT0 8'hff
`define RST_ANADIG_PORT2 8'hff
`define RST_FLASH_MODE 8'h08
`endif

// ### inc/xsfr_pkg.sv
// Types shared by the extended register bank and its users
package xsfr_pkg;
   // Access width requested by the core
   typedef enum logic [1:0] {W_BIT = 2'b00, W_BYTE = 2'b01, W_WORD = 2'b10} acc_width_type;
   // Source of the reset that just ended
   typedef enum logic [2:0] {
      SRC_PIN = 3'b000,
      SRC_ILLEGAL = 3'b001,
      SRC_WDOG = 3'b010,
      SRC_BADMEM = 3'b011,
      SRC_SUPPLY = 3'b100,
      SRC_RETENTION = 3'b101
   } reset_src_type;
   // Bring-up sequence after reset release
   typedef enum logic {ST_CAPTURE = 1'b0, ST_RUN = 1'b1} boot_state_type;
   // One access from the core
   typedef struct packed {
      logic valid;
      logic wr;
      acc_width_type width;
      logic [19:0] addr;
      logic [2:0] bitpos;
      logic [15:0] wdata;
   } cpu_req_type;
   // Answer to one access
   typedef struct packed {
      logic ack;
      logic err;
      logic ext;
      logic [15:0] rdata;
   } cpu_rsp_type;
   // Read-only values owned by other hardware
   typedef struct packed {
      logic [7:0] flash_stat_lo;
      logic [7:0] flash_stat_hi;
      logic [7:0] decimal_adjust;
   } ro_status_type;
endpackage : xsfr_pkg

// ### core/xsfr_bank.sv
// Extended register area decode, storage and reset-cause flags
`timescale 1ns/1ps
`default_nettype none
`include "xsfr_cfg.svh"

module xsfr_bank #(
   parameter logic [7:0] TRIM_RST = 8'h00, // Trim reset value, set by fuse load
   parameter logic [7:0] DIV_RST = 8'h00 // Divider reset value, set by fuse load
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire xsfr_pkg::reset_src_type rst_src,
   input wire logic opt_wdog_on,
   input wire xsfr_pkg::cpu_req_type cpu_req,
   output logic cpu_ready,
   output xsfr_pkg::cpu_rsp_type cpu_rsp,
   input wire xsfr_pkg::ro_status_type ro_status,
   output logic [34*8-1:0] ctrl_bytes,
   output logic [7:0] reset_cause_register,
   output logic [7:0] watchdog_enable_register
);
   import xsfr_pkg::*;

   // Access timing, as seen by the core:
   // - Request taken at a rising edge with valid and ready high
   // - Answer registered, standing for exactly one cycle after
   // - Back-to-back requests allowed on every cycle
   // - Ready low for one capture cycle after each reset release
   // Refusals answer with err set and zero read data:
   // - 16-bit width, since no byte here lists it
   // - Bit width on bytes without bit access
   // - Addresses with no register behind them
   // Writes to read-only bytes are acknowledged without err,
   // but change nothing; the owning hardware keeps its value.
   // Primary-area decode covers only the cause and watchdog bytes;
   // every other primary address belongs to another bank.
   // Each access moves one byte or one bit; there is no
   // pairing of bytes into words anywhere in this area.

   localparam int NRW = 34; // Number of read/write bytes in the area
   // Read-only bytes are not counted in NRW; they are decoded apart

   // Address of each read/write byte, in table order
   // Table order fixes the ctrl_bytes layout; adding a byte
   // means extending all three tables and NRW together.
   localparam logic [19:0] RW_ADDR [NRW] = '{
      `OFS_ADC_MODE_TWO, `OFS_ADC_TEST_SELECT, `OFS_PULLUP_PORT0,
      `OFS_PULLUP_PORT2, `OFS_PULLUP_PORT4, `OFS_PULLUP_PORT12,
      `OFS_INPUT_LEVEL_PORT14, `OFS_OUTPUT_TYPE_PORT0,
      `OFS_OUTPUT_TYPE_PORT2, `OFS_OUTPUT_TYPE_PORT4, `OFS_ANADIG_PORT0,
      `OFS_ANADIG_PORT2, `OFS_GLITCH_EN0, `OFS_GLITCH_EN1,
      `OFS_INPUT_SWITCH, `OFS_PIN_REDIRECT2, `OFS_PIN_REDIRECT0,
      `OFS_PIN_REDIRECT1, `OFS_PIN_REDIRECT3, `OFS_FAST_OSC_TRIM,
      `OFS_FAST_OSC_DIV, `OFS_FLASH_FREQ, `OFS_FLASH_MODE,
      `OFS_FLASH_SEQ_CTRL, `OFS_FLASH_PTR_LO, `OFS_FLASH_PTR_HI,
      `OFS_FLASH_END_LO, `OFS_FLASH_END_HI, `OFS_FLASH_WBUF0,
      `OFS_FLASH_WBUF1, `OFS_FLASH_WBUF2, `OFS_FLASH_WBUF3,
      `OFS_PERIPH_CLK_EN0, `OFS_SPEED_MODE
   };

   // After-reset value of each read/write byte
   // Trim and divider defaults come from parameters, since
   // their real values are loaded from fuses at power-up.
   localparam logic [7:0] RW_RST [NRW] = '{
      `RST_ZERO, `RST_ZERO, `RST_ZERO, `RST_ZERO, `RST_PULLUP_PORT4,
      `RST_ZERO, `RST_ZERO, `RST_ZERO, `RST_ZERO, `RST_ZERO,
      `RST_ANADIG_PORT0, `RST_ANADIG_PORT2, `RST_ZERO, `RST_ZERO,
      `RST_ZERO, `RST_ZERO, `RST_ZERO, `RST_ZERO, `RST_ZERO,
      TRIM_RST, DIV_RST, `RST_ZERO, `RST_FLASH_MODE, `RST_ZERO,
      `RST_ZERO, `RST_ZERO, `RST_ZERO, `RST_ZERO, `RST_ZERO,
      `RST_ZERO, `RST_ZERO, `RST_ZERO, `RST_ZERO, `RST_ZERO
   };

   // Bytes that also allow single-bit access; none allows 16-bit
   // Bit i set: byte i of the tables accepts bit access.
   // A wrong bit here only shows up as a bit access wrongly refused or taken.
   localparam logic [NRW-1:0] RW_BIT_OK = 34'h100007ffd;

   // Bring-up state
   boot_state_type state_r;
   boot_state_type state_nxt;

   // Stored bytes and status
   logic [7:0] byte_r [NRW]; // Read/write bytes
   logic [3:0] flags_r; // Reset-cause flags, survive reset
   logic [3:0] flags_nxt; // Flags after this reset's source
   logic [7:0] wden_r; // Watchdog enable byte

   // Decode results
   logic take; // Request accepted this edge
   logic in_ext; // Address inside extended area
   logic in_pri; // Address inside primary area
   logic [NRW-1:0] rw_hit; // One-hot read/write byte hit
   logic hit_stat_lo; // Flash status low hit
   logic hit_stat_hi; // Flash status high hit
   logic hit_bcd; // Decimal adjust result hit
   logic hit_cause; // Reset cause byte hit
   logic hit_wden; // Watchdog enable byte hit
   logic ro_hit; // Any read-only byte hit
   logic mapped; // Some register answers
   logic bit_ok; // Bit access allowed here
   logic acc_ok; // Width allowed and register present
   logic wr_en; // Accepted write to storage
   logic [7:0] rd_byte; // Read value before width shaping
   logic [7:0] rd_nxt; // Read value sent to the core
   cpu_rsp_type rsp_nxt; // Next answer

   // Area decode; primary and extended never overlap
   // Full 20-bit compares; no partial decode, so aliases
   // of a register never answer.
   assign in_ext = (cpu_req.addr >= `EXT_AREA_LO) && (cpu_req.addr <= `EXT_AREA_HI);
   assign in_pri = (cpu_req.addr >= `PRI_AREA_LO) && (cpu_req.addr <= `PRI_AREA_HI);

   // Per-byte address match and storage
   // One storage slice per byte: address match, register,
   // and its lane on the control bus to the peripherals.
   genvar gi;
   generate
      for (gi = 0; gi < NRW; gi++) begin : g_rw
         // Match only inside the extended window
         assign rw_hit[gi] = in_ext && (cpu_req.addr == RW_ADDR[gi]);

         // Byte storage; listed value on every reset
         always_ff @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
               byte_r[gi] <= RW_RST[gi];
            end else if (wr_en && rw_hit[gi]) begin
               // Write enable already holds the width check
               // Bit write touches one bit only
               if (cpu_req.width == W_BIT) begin
                  byte_r[gi][cpu_req.bitpos] <= cpu_req.wdata[0];
               end else begin
                  // Byte write takes the low data lane
                  byte_r[gi] <= cpu_req.wdata[7:0];
               end
            end
         end

         // Control bytes out to the peripherals
         // Peripherals see a write in the cycle after it is taken
         assign ctrl_bytes[gi*8 +: 8] = byte_r[gi];
      end
   endgenerate

   // Read-only bytes are driven by their owners and only
   // read back here; no copy is stored in this bank.
   // Read-only and primary-area hits
   assign hit_stat_lo = in_ext && (cpu_req.addr == `OFS_FLASH_STAT_LO);
   assign hit_stat_hi = in_ext && (cpu_req.addr == `OFS_FLASH_STAT_HI);
   assign hit_bcd = in_ext && (cpu_req.addr == `OFS_DECIMAL_ADJUST);
   assign hit_cause = in_pri && (cpu_req.addr == `ADDR_RESET_CAUSE);
   assign hit_wden = in_pri && (cpu_req.addr == `ADDR_WDOG_ENABLE);
   assign ro_hit = hit_stat_lo || hit_stat_hi || hit_bcd || hit_cause;

   // Width check; 16-bit refused since no byte here lists it
   // An access is good only if some register answers and
   // the width is one that register lists.
   assign mapped = (|rw_hit) || ro_hit || hit_wden;
   assign bit_ok = |(rw_hit & RW_BIT_OK);
   assign acc_ok = mapped && ((cpu_req.width == W_BYTE) || ((cpu_req.width == W_BIT) && bit_ok));

   // Requests only once reset capture is over
   // Ready comes straight from the state register, so it is
   // free of glitches and rises one edge after release.
   assign cpu_ready = (state_r == ST_RUN);
   assign take = cpu_req.valid && cpu_ready;

   // Read-only bytes never take a write
   // Refused accesses never reach storage either
   assign wr_en = take && cpu_req.wr && acc_ok && !ro_hit;

   // Read mux
   // Hits are one-hot, so the order of the ifs below does
   // not matter; zero stays when nothing hits.
   always_comb begin
      rd_byte = 8'h00; // Unassigned reads as zero
      for (int i = 0; i < NRW; i++) begin
         if (rw_hit[i]) begin
            rd_byte = byte_r[i];
         end
      end
      // Read-only sources
      if (hit_stat_lo) begin
         rd_byte = ro_status.flash_stat_lo;
      end
      if (hit_stat_hi) begin
         rd_byte = ro_status.flash_stat_hi;
      end
      if (hit_bcd) begin
         rd_byte = ro_status.decimal_adjust;
      end
      // Cause byte lives in the primary area
      if (hit_cause) begin
         rd_byte = reset_cause_register;
      end
      if (hit_wden) begin
         rd_byte = wden_r;
      end
      // Width shaping and refusal
      if (!acc_ok) begin
         rd_nxt = 8'h00;
      end else if (cpu_req.width == W_BIT) begin
         // Selected bit returned in the lowest lane
         rd_nxt = {7'h00, rd_byte[cpu_req.bitpos]};
      end else begin
         rd_nxt = rd_byte;
      end
   end

   // Answer assembly
   // Upper data lane always zero: no 16-bit register here.
   // Writes and refusals return zero data.
   // Ext marks accesses that cost the longer instruction form
   always_comb begin
      rsp_nxt = '0;
      rsp_nxt.ack = take;
      rsp_nxt.err = take && !acc_ok;
      rsp_nxt.ext = take && in_ext;
      if (take && !cpu_req.wr) begin
         rsp_nxt.rdata = {8'h00, rd_nxt};
      end
   end

   // Answer register, one cycle after acceptance
   // Registered so the core sees clean pulses; every field
   // falls back to zero after each edge that takes no access.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         // Nothing pending across a reset
         cpu_rsp <= '0;
      end else begin
         cpu_rsp <= rsp_nxt;
      end
   end

   // Bring-up: one capture cycle after release
   // The capture cycle gives the option byte and reset source
   // one full cycle to settle before the core may access.
   always_comb begin
      case (state_r)
         // Capture lasts exactly one cycle
         ST_CAPTURE: state_nxt = ST_RUN;
         ST_RUN: state_nxt = ST_RUN;
         default: state_nxt = ST_CAPTURE;
      endcase
   end

   // State register
   // Returns to capture on every reset
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= ST_CAPTURE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Flag update for the reset source just ended
   // The source input must stay steady from release through
   // the capture edge; a change there records the wrong cause.
   // Codes not listed leave all flags as they were.
   always_comb begin
      flags_nxt = flags_r;
      case (rst_src)
         // Pin reset clears the cause byte
         SRC_PIN: begin
            flags_nxt = 4'h0;
         end
         // Illegal instruction sets only the trap flag
         SRC_ILLEGAL: begin
            flags_nxt[`RCR_BIT_TRAP] = 1'b1;
         end
         // Watchdog overflow sets only its own flag
         SRC_WDOG: begin
            flags_nxt[`RCR_BIT_WDOG] = 1'b1;
         end
         // Bad memory access sets only its own flag
         SRC_BADMEM: begin
            flags_nxt[`RCR_BIT_BADMEM] = 1'b1;
         end
         // Supply power-on sets only its own flag
         SRC_SUPPLY: begin
            flags_nxt[`RCR_BIT_SUPPLY] = 1'b1;
         end
         // Retention-voltage reset wipes all causes
         SRC_RETENTION: begin
            flags_nxt = 4'h0;
         end
         // Unused codes keep the flags
         default: begin
            flags_nxt = flags_r;
         end
      endcase
   end

   // Cause flags have no async reset: they must survive it.
   // Power-up arrives as a retention reset, which defines them.
   // Limitation: until the first capture after power-up the
   // flags read as unknown in simulation.
   always_ff @(posedge clk_sys) begin
      if (state_r == ST_CAPTURE) begin
         flags_r <= flags_nxt;
      end
   end

   // Cause byte, upper bits read as zero
   // Writes never reach it; the decode marks it read-only
   assign reset_cause_register = {4'h0, flags_r};

   // Watchdog enable: constant under reset, option byte caught at release
   // The option byte is only looked at on the capture edge,
   // so a later change of it waits for the next reset.
   // Core writes are plain byte stores, no side effect here.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         wden_r <= `WDOG_EN_RST_OFF;
      end else if (state_r == ST_CAPTURE) begin
         // Option byte picks one of the two reset values
         wden_r <= opt_wdog_on ? `WDOG_EN_RST_ON : `WDOG_EN_RST_OFF;
      end else if (wr_en && hit_wden) begin
         // Core write, byte width only
         wden_r <= cpu_req.wdata[7:0];
      end
   end

   // Watchdog enable byte to the watchdog unit
   // Straight from the register, no decode on the way
   assign watchdog_enable_register = wden_r;

endmodule : xsfr_bank
`default_nettype wire

// ### verif/xsfr_bank_chk.sv
// Port-level checks for the extended register bank
`timescale 1ns/1ps
`default_nettype none
`include "xsfr_cfg.svh"
module xsfr_bank_chk (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire xsfr_pkg::reset_src_type rst_src,
   input wire logic opt_wdog_on,
   input wire xsfr_pkg::cpu_req_type cpu_req,
   input wire logic cpu_ready,
   input wire xsfr_pkg::cpu_rsp_type cpu_rsp,
   input wire logic [34*8-1:0] ctrl_bytes,
   input wire logic [7:0] reset_cause_register,
   input wire logic [7:0] watchdog_enable_register
);
   import xsfr_pkg::*;
   logic take; // Access taken this edge
   logic in_ext; // Address inside the extended area
   assign take = cpu_req.valid && cpu_ready;
   assign in_ext = (cpu_req.addr >= `EXT_AREA_LO) && (cpu_req.addr <= `EXT_AREA_HI);
   // One domain, so clock and reset are given once
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   ack_pulse_a: assert property (take |=> cpu_rsp.ack) else $error("no answer to access");
   ext_mark_a: assert property (take |=> cpu_rsp.ext == $past(in_ext)) else $error("area mark wrong");
   word_refuse_a: assert property (take && cpu_req.width == W_WORD |=>
      cpu_rsp.err && cpu_rsp.rdata == 16'h0000) else $error("word access not refused");
   unmapped_zero_a: assert property (take && cpu_req.addr == `EXT_AREA_HI |=>
      cpu_rsp.err && cpu_rsp.rdata == 16'h0000) else $error("unassigned address answered");
   cause_ro_a: assert property (take && cpu_req.wr |=> $stable(reset_cause_register))
      else $error("cause flags changed by write");
   ctrl_hold_a: assert property (!(take && cpu_req.wr) |=> $stable(ctrl_bytes)) else $error("control byte moved");
   wdog_load_a: assert property ($rose(cpu_ready) |-> watchdog_enable_register ==
      ($past(opt_wdog_on) ? `WDOG_EN_RST_ON : `WDOG_EN_RST_OFF)) else $error("watchdog reset value wrong");
   cause_clear_a: assert property ($rose(cpu_ready) && $past(rst_src) inside {SRC_PIN, SRC_RETENTION}
      |-> reset_cause_register == 8'h00) else $error("flags not cleared");
   trap_set_a: assert property ($rose(cpu_ready) && $past(rst_src) == SRC_ILLEGAL
      |-> reset_cause_register[`RCR_BIT_TRAP]) else $error("trap flag not set");
   reset_value_a: assert property ($rose(cpu_ready) |-> ctrl_bytes[39:32] == `RST_PULLUP_PORT4
      && ctrl_bytes[95:80] == 16'hffff) else $error("reset value wrong");
endmodule : xsfr_bank_chk
`default_nettype wire

// ### verif/cpu_core_model.sv
// Core-side access model for the extended register bank
`timescale 1ns/1ps
`default_nettype none
module cpu_core_model (
   input wire logic clk_sys,
   output xsfr_pkg::cpu_req_type cpu_req,
   input wire logic cpu_ready,
   input wire xsfr_pkg::cpu_rsp_type cpu_rsp
);
   import xsfr_pkg::*;
   initial cpu_req = '0;
   // One access: held until taken, answer picked up in the following cycle
   task automatic xfer(input logic wr, input acc_width_type w, input logic [19:0] a, input logic [2:0] bp,
                       input logic [7:0] d, output cpu_rsp_type rsp, output logic ok);
      int n;
      n = 0;
      @(posedge clk_sys);
      cpu_req <= '{valid: 1'b1, wr: wr, width: w, addr: a, bitpos: bp, wdata: {8'h00, d}};
      do begin
         @(posedge clk_sys);
         n++;
      end while (!cpu_ready && n < 20);
      // Released lines show garbage, not the last value
      cpu_req <= '{valid: 1'b0, wr: ~wr, width: w, addr: ~a, bitpos: ~bp, wdata: {8'hff, ~d}};
      #1;
      rsp = cpu_rsp;
      ok = (n < 20);
   endtask : xfer
endmodule : cpu_core_model
`default_nettype wire

// ### verif/extended_sfr_area_and_reset_flags_tb_top.sv
// Self-checking bench for the extended register bank
`timescale 1ns/1ps
`default_nettype none
`include "xsfr_cfg.svh"
module extended_sfr_area_and_reset_flags_tb_top;
   import xsfr_pkg::*;
   logic clk_sys, rst_n, opt_wdog_on, cpu_ready;
   reset_src_type rst_src;
   cpu_req_type cpu_req;
   cpu_rsp_type cpu_rsp;
   ro_status_type ro_status;
   logic [34*8-1:0] ctrl_bytes;
   logic [7:0] reset_cause_register, watchdog_enable_register;
   int n_errors = 0;
   int tests_run = 0;
   int cycles = 0;
   logic [19:0] ra [6] = '{`OFS_ADC_MODE_TWO, `OFS_PULLUP_PORT4, `OFS_ANADIG_PORT0, `OFS_ANADIG_PORT2,
                           `OFS_FLASH_MODE, `OFS_SPEED_MODE};
   logic [7:0] rv [6] = '{8'h00, 8'h01, 8'hff, 8'hff, 8'h08, 8'h00};
   reset_src_type srcs [7] = '{SRC_ILLEGAL, SRC_WDOG, SRC_BADMEM, SRC_SUPPLY, SRC_RETENTION, SRC_WDOG, SRC_PIN};
   logic [7:0] flags [7] = '{8'h08, 8'h0c, 8'h0e, 8'h0f, 8'h00, 8'h04, 8'h00};

   xsfr_bank DUT (.clk_sys(clk_sys), .rst_n(rst_n), .rst_src(rst_src), .opt_wdog_on(opt_wdog_on),
      .cpu_req(cpu_req), .cpu_ready(cpu_ready), .cpu_rsp(cpu_rsp), .ro_status(ro_status),
      .ctrl_bytes(ctrl_bytes), .reset_cause_register(reset_cause_register),
      .watchdog_enable_register(watchdog_enable_register));
   cpu_core_model u_cpu (.clk_sys(clk_sys), .cpu_req(cpu_req), .cpu_ready(cpu_ready), .cpu_rsp(cpu_rsp));

   // Free-running system clock
   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end

   // Hang guard, well above the roughly 160 cycles the run needs
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         end_sim();
      end
   end

   task automatic chk(input logic [19:0] got, input logic [19:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // One access with its expected answer; area mark worked out from the address
   task automatic acc(input logic wr, input acc_width_type w, input logic [19:0] a, input logic [2:0] bp,
                      input logic [7:0] d, input logic e, input logic [15:0] r);
      cpu_rsp_type rsp;
      logic ok;
      logic x;
      x = (a >= `EXT_AREA_LO) && (a <= `EXT_AREA_HI);
      u_cpu.xfer(wr, w, a, bp, d, rsp, ok);
      chk({ok, rsp.ack, rsp.err, rsp.ext, rsp.rdata}, {1'b1, 1'b1, e, x, r});
   endtask : acc

   // Reset from a given source, then check flags and watchdog value
   task automatic do_reset(input reset_src_type src, input logic opt, input logic [7:0] f);
      @(posedge clk_sys); // Reset and its source change on a rising edge
      rst_n <= 1'b0;
      rst_src <= src;
      opt_wdog_on <= opt;
      repeat (8) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk_sys);
      chk({4'h0, reset_cause_register, watchdog_enable_register},
          {4'h0, f, opt ? `WDOG_EN_RST_ON : `WDOG_EN_RST_OFF});
      acc(0, W_BYTE, `ADDR_RESET_CAUSE, 0, 0, 0, {8'h00, f});
   endtask : do_reset

   task automatic end_sim();
      $display("errors %0d of %0d checks", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : end_sim

   // Main sequence
   initial begin
      rst_n = 1'b0;
      rst_src = SRC_PIN;
      opt_wdog_on = 1'b0;
      ro_status = '{flash_stat_lo: 8'h3c, flash_stat_hi: 8'hc3, decimal_adjust: 8'h59};
      do_reset(SRC_PIN, 1'b0, 8'h00);
      for (int i = 0; i < 6; i++) acc(0, W_BYTE, ra[i], 0, 0, 0, {8'h00, rv[i]});
      acc(1, W_BYTE, `OFS_ADC_MODE_TWO, 0, 8'h5a, 0, 16'h0000);
      chk({12'h000, ctrl_bytes[7:0]}, {12'h000, 8'h5a});
      acc(0, W_BYTE, `OFS_ADC_MODE_TWO, 0, 0, 0, 16'h005a);
      acc(1, W_BIT, `OFS_PULLUP_PORT4, 3'd3, 8'h01, 0, 16'h0000);
      acc(0, W_BYTE, `OFS_PULLUP_PORT4, 0, 0, 0, 16'h0009);
      acc(0, W_BIT, `OFS_ANADIG_PORT0, 3'd7, 0, 0, 16'h0001);
      acc(1, W_BIT, `OFS_ADC_TEST_SELECT, 3'd1, 8'h01, 1, 16'h0000);
      acc(0, W_BYTE, `OFS_ADC_TEST_SELECT, 0, 0, 0, 16'h0000);
      acc(0, W_WORD, `OFS_ADC_MODE_TWO, 0, 0, 1, 16'h0000);
      acc(1, W_BYTE, `OFS_FLASH_STAT_LO, 0, 8'hff, 0, 16'h0000);
      acc(0, W_BYTE, `OFS_FLASH_STAT_LO, 0, 0, 0, 16'h003c);
      acc(0, W_BYTE, `OFS_FLASH_STAT_HI, 0, 0, 0, 16'h00c3);
      acc(0, W_BYTE, `OFS_DECIMAL_ADJUST, 0, 0, 0, 16'h0059);
      acc(1, W_BYTE, `EXT_AREA_HI, 0, 8'h77, 1, 16'h0000);
      acc(0, W_BYTE, `EXT_AREA_HI, 0, 0, 1, 16'h0000);
      acc(0, W_BYTE, `EXT_AREA_LO, 0, 0, 1, 16'h0000);
      acc(0, W_BYTE, `PRI_AREA_LO, 0, 0, 1, 16'h0000);
      acc(1, W_BYTE, `ADDR_WDOG_ENABLE, 0, 8'h44, 0, 16'h0000);
      acc(0, W_BYTE, `ADDR_WDOG_ENABLE, 0, 0, 0, 16'h0044);
      acc(1, W_BYTE, `ADDR_RESET_CAUSE, 0, 8'hff, 0, 16'h0000);
      for (int i = 0; i < 7; i++) do_reset(srcs[i], i[0], flags[i]);
      acc(0, W_BYTE, `OFS_ADC_MODE_TWO, 0, 0, 0, 16'h0000);
      acc(0, W_BYTE, `OFS_PULLUP_PORT4, 0, 0, 0, 16'h0001);
      end_sim();
   end
endmodule : extended_sfr_area_and_reset_flags_tb_top

bind xsfr_bank xsfr_bank_chk u_chk (.clk_sys(clk_sys), .rst_n(rst_n), .rst_src(rst_src),
   .opt_wdog_on(opt_wdog_on), .cpu_req(cpu_req), .cpu_ready(cpu_ready), .cpu_rsp(cpu_rsp),
   .ctrl_bytes(ctrl_bytes), .reset_cause_register(reset_cause_register),
   .watchdog_enable_register(watchdog_enable_register));
`default_nettype wire
